// ==== src/uart_int_consts.svh ====
`ifndef UART_INT_CONSTS_SVH
`define UART_INT_CONSTS_SVH

// Host register offsets
`define OFS_RX_HOLDING 4'h0
`define OFS_TX_HOLDING 4'h0
`define OFS_INT_MASK 4'h1
`define OFS_INT_SOURCE 4'h2
`define OFS_FIFO_SETUP 4'h2
`define OFS_LINE_STATUS 4'h5
`define OFS_MODEM_STATUS 4'h6
`define OFS_INPUT_STATE 4'hb

// Reset values
`define RST_INT_MASK 8'h00
`define RST_TX_TRIG 2'h0
`define RST_RX_TRIG 2'h0

// Interrupt mask fields
`define IM_RX_READY 0
`define IM_TX_READY 1
`define IM_LINE 2
`define IM_MODEM 3
`define IM_XOFF 5
`define IM_RTS 6
`define IM_CTS 7
`define IM_LOCKED_MASK 8'hf0

// Fifo setup fields
`define FS_ENABLE 0
`define FS_RX_RESET 1
`define FS_TX_RESET 2

// Source codes, status bits 5:0
`define SRC_LINE 6'h06
`define SRC_RX_TIMEOUT 6'h0c
`define SRC_RX_READY 6'h04
`define SRC_TX_READY 6'h02
`define SRC_MODEM 6'h00
`define SRC_INPUT 6'h30
`define SRC_XOFF 6'h10
`define SRC_FLOW 6'h20
`define SRC_NONE 6'h01

// Trigger levels
`define RX_TRIG_0 7'h08
`define RX_TRIG_1 7'h10
`define RX_TRIG_2 7'h38
`define RX_TRIG_3 7'h3c
`define TX_TRIG_0 7'h08
`define TX_TRIG_1 7'h10
`define TX_TRIG_2 7'h20
`define TX_TRIG_3 7'h38

// Time-out: character times and extra bit times
`define TMO_CHARS 7'h04
`define TMO_BITS 7'h0c

`endif

// ==== src/uart_int_pkg.sv ====
package uart_int_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} host_req_t;

	typedef struct packed {
		logic [6:0] level;
		logic data_ready;
		logic [2:0] head_err;
		logic err_in_fifo;
		logic overrun_evt;
		logic char_in;
	} rx_status_t;

	typedef struct packed {
		logic [6:0] spaces;
		logic thr_empty;
		logic tx_empty;
	} tx_status_t;

	typedef struct packed {
		logic unlock;
		logic auto_rs485;
		logic auto_rts;
		logic auto_cts;
		logic rts_out;
		logic cts_in;
		logic msr_delta;
		logic xoff_match;
		logic xon_match;
		logic special_match;
	} flow_status_t;

endpackage

// ==== src/rx_timeout_timer.sv ====
`timescale 1ns/1ns
`include "uart_int_consts.svh"

module rx_timeout_timer #(
	parameter int CW = 7
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic bit_tick,
	input wire logic [3:0] char_bits,
	input wire logic restart,
	input wire logic data_waiting,
	output logic expire
);
	logic [CW-1:0] count;
	logic fired;
	wire [CW-1:0] limit = CW'({3'h0, char_bits} * `TMO_CHARS + `TMO_BITS);
	wire hit = bit_tick && !fired && data_waiting && (count + 1'b1 >= limit);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
			fired <= 1'b0;
			expire <= 1'b0;
		end else begin
			expire <= hit;
			if (restart || !data_waiting) begin
				count <= '0;
				fired <= 1'b0;
			end else if (hit) begin
				fired <= 1'b1;
			end else if (bit_tick && !fired) begin
				count <= count + 1'b1;
			end
		end
	end

	a_expire_once: assert property (@(posedge ref_clk) disable iff (sys_rst)
		expire |=> !expire) else $error("time-out pulse held"); // see RL10
endmodule // rx_timeout_timer

// ==== src/uart_interrupt_fifo_control.sv ====
// What this block does
// (RL1) Transmit-ready raises on holding empty, or spaces above trigger in fifo mode.
// (RL2) Enabling transmit-ready while holding already empty raises it at once.
// (RL3) Line status interrupt when status bits 1,2,3,4 or 7 set.
// (RL4) Overrun interrupts at once when the causing character arrives.
// (RL5) Status bit 7 marks errored entries; interrupt holds while it stays set.
// (RL6) Status bits 4:2 show errors of the character at fifo head.
// (RL7) Mask bits 7:4 writable only when enhanced features unlocked; reset zero.
// (RL8) Interrupt on low-to-high of flow pins under automatic flow control.
// (RL9) Status read shows only top pending source; others stay queued.
// (RL10) Time-out after four characters plus twelve bits with data waiting.
// (RL11) Transmit-ready uses whole-transmitter empty in half-duplex direction mode.
// (RL12) Input toggle interrupt, cleared by reading the input state register.
// (RL13) Line clears when errors gone; ready below trigger; time-out on read.
// (RL14) Transmit-ready clears on status read or holding register write.
// (RL15) Modem/flow clear on modem read; Xoff on Xon; special on status read.
// (RL16) Status bits 5:0 encode eight priorities; none pending reads 000001.
// (RL17) Status bit 0 low while pending, high when none and after reset.
// (RL18) Status bits 7:6 both follow the fifo enable.
// (RL19) Fifo setup bit 0 enables fifos; other bits programmed only with it.
// (RL20) Fifo reset bits pulse pointer resets once, then self-clear.
// (RL21) Transmit trigger select needs unlock; fires above trigger or on empty.
// (RL22) Xoff or special character match sets status bit 4 when enabled.
// (RL23) Receive triggers 8,16,56,60; transmit triggers 8,16,32,56.
// (RL24) Interrupt output active while any enabled source is pending.
`timescale 1ns/1ns
`include "uart_int_consts.svh"

module uart_interrupt_fifo_control #(
	parameter int GPIO_W = 8
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire uart_int_pkg::host_req_t host,
	input wire uart_int_pkg::rx_status_t rx,
	input wire uart_int_pkg::tx_status_t tx,
	input wire uart_int_pkg::flow_status_t flow,
	input wire logic [GPIO_W-1:0] gpio_in,
	input wire logic bit_tick,
	input wire logic [3:0] char_bits,
	output logic [7:0] rd_data,
	output logic irq,
	output logic fifo_enable,
	output logic rx_fifo_reset,
	output logic tx_fifo_reset,
	output logic [1:0] tx_trig_sel,
	output logic [1:0] rx_trig_sel,
	output logic sleep_enable,
	output logic overrun_flag
);
	logic [7:0] interrupt_mask_reg;
	logic tx_pend, tmo_pend, gpio_pend, xoff_pend, spec_pend, flow_pend;
	logic tx_above_q, tx_empty_q, rts_q, cts_q;
	logic [GPIO_W-1:0] gpio_q;
	logic tmo_expire;

	// Host access decode
	wire wr_mask = host.wr && host.addr == `OFS_INT_MASK;
	wire wr_fifo = host.wr && host.addr == `OFS_FIFO_SETUP;
	wire wr_thr = host.wr && host.addr == `OFS_TX_HOLDING;
	wire rd_isr = host.rd && host.addr == `OFS_INT_SOURCE;
	wire rd_rhr = host.rd && host.addr == `OFS_RX_HOLDING;
	wire rd_lsr = host.rd && host.addr == `OFS_LINE_STATUS;
	wire rd_msr = host.rd && host.addr == `OFS_MODEM_STATUS;
	wire rd_io = host.rd && host.addr == `OFS_INPUT_STATE;

	// Locked mask bits keep their value unless unlocked
	wire [7:0] next_mask = flow.unlock ? host.wdata : // see RL7
		((host.wdata & ~`IM_LOCKED_MASK) |
		(interrupt_mask_reg & `IM_LOCKED_MASK));
	wire tx_en_rise = wr_mask && host.wdata[`IM_TX_READY] &&
		!interrupt_mask_reg[`IM_TX_READY];

	// Trigger levels
	wire [6:0] rx_trig = (rx_trig_sel == 2'h0) ? `RX_TRIG_0 : // see RL23
		(rx_trig_sel == 2'h1) ? `RX_TRIG_1 :
		(rx_trig_sel == 2'h2) ? `RX_TRIG_2 : `RX_TRIG_3;
	wire [6:0] tx_trig = (tx_trig_sel == 2'h0) ? `TX_TRIG_0 : // see RL23
		(tx_trig_sel == 2'h1) ? `TX_TRIG_1 :
		(tx_trig_sel == 2'h2) ? `TX_TRIG_2 : `TX_TRIG_3;

	// Transmit-ready conditions
	wire tx_fifo_empty = tx.spaces == 7'h40;
	wire tx_above = flow.auto_rs485 ? tx.tx_empty : // see RL11
		fifo_enable ? (tx.spaces > tx_trig) : tx.thr_empty; // see RL1
	wire tx_empty_now = fifo_enable && !flow.auto_rs485 && tx_fifo_empty;
	wire tx_ready_cond = tx_above || tx_empty_now;
	wire tx_set = (tx_above && !tx_above_q) || // see RL21
		(tx_empty_now && !tx_empty_q) ||
		(tx_en_rise && tx_ready_cond); // see RL2

	// Level sources
	wire line_err = overrun_flag || (|rx.head_err) || // see RL6
		rx.err_in_fifo; // see RL5
	wire rx_ready = fifo_enable ? (rx.level >= rx_trig) : rx.data_ready;
	wire data_waiting = fifo_enable ? (rx.level != 7'h00) : rx.data_ready;

	// Enabled pending sources
	wire p_line = interrupt_mask_reg[`IM_LINE] && line_err; // see RL3
	wire p_tmo = interrupt_mask_reg[`IM_RX_READY] && tmo_pend;
	wire p_rx = interrupt_mask_reg[`IM_RX_READY] && rx_ready; // see RL13
	wire p_tx = interrupt_mask_reg[`IM_TX_READY] && tx_pend;
	wire p_msr = interrupt_mask_reg[`IM_MODEM] && flow.msr_delta;
	wire p_gpio = gpio_pend;
	wire p_xoff = xoff_pend || spec_pend;
	wire p_flow = flow_pend;
	wire any_pend = p_line || p_tmo || p_rx || p_tx || p_msr || p_gpio ||
		p_xoff || p_flow;

	// Priority encoding, highest first
	wire [5:0] src_code = p_line ? `SRC_LINE : // see RL16
		p_tmo ? `SRC_RX_TIMEOUT :
		p_rx ? `SRC_RX_READY :
		p_tx ? `SRC_TX_READY :
		p_msr ? `SRC_MODEM :
		p_gpio ? `SRC_INPUT :
		p_xoff ? `SRC_XOFF :
		p_flow ? `SRC_FLOW : `SRC_NONE; // see RL17
	wire [7:0] isr_value = {{2{fifo_enable}}, src_code}; // see RL18
	// A status read only services the source it reports
	wire tx_served = rd_isr && src_code == `SRC_TX_READY; // see RL9
	wire spec_served = rd_isr && src_code == `SRC_XOFF && !xoff_pend;

	wire [7:0] next_rd = (host.addr == `OFS_INT_MASK) ? interrupt_mask_reg :
		(host.addr == `OFS_INT_SOURCE) ? isr_value : 8'h00;

	// Event edges
	wire gpio_toggle = |(gpio_in ^ gpio_q); // see RL12
	wire flow_set = (flow.unlock && interrupt_mask_reg[`IM_RTS] &&
		flow.auto_rts && flow.rts_out && !rts_q) || // see RL8
		(flow.unlock && interrupt_mask_reg[`IM_CTS] &&
		flow.auto_cts && flow.cts_in && !cts_q);
	wire xoff_gate = flow.unlock && interrupt_mask_reg[`IM_XOFF];

	rx_timeout_timer #(
		.CW(7)
	) u_timer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.bit_tick(bit_tick),
		.char_bits(char_bits),
		.restart(rx.char_in || rd_rhr),
		.data_waiting(data_waiting),
		.expire(tmo_expire)
	);

	// Host-written registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			interrupt_mask_reg <= `RST_INT_MASK;
			fifo_enable <= 1'b0;
			rx_fifo_reset <= 1'b0;
			tx_fifo_reset <= 1'b0;
			tx_trig_sel <= `RST_TX_TRIG;
			rx_trig_sel <= `RST_RX_TRIG;
		end else begin
			rx_fifo_reset <= wr_fifo && host.wdata[`FS_ENABLE] &&
				host.wdata[`FS_RX_RESET]; // see RL20
			tx_fifo_reset <= wr_fifo && host.wdata[`FS_ENABLE] &&
				host.wdata[`FS_TX_RESET]; // see RL20
			if (wr_mask)
				interrupt_mask_reg <= next_mask;
			if (wr_fifo) begin
				fifo_enable <= host.wdata[`FS_ENABLE];
				if (host.wdata[`FS_ENABLE]) begin // see RL19
					rx_trig_sel <= host.wdata[7:6];
					if (flow.unlock)
						tx_trig_sel <= host.wdata[5:4]; // see RL21
				end
			end
		end
	end

	// Sticky sources: set wins over clear
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_pend <= 1'b0;
			tmo_pend <= 1'b0;
			gpio_pend <= 1'b0;
			xoff_pend <= 1'b0;
			spec_pend <= 1'b0;
			flow_pend <= 1'b0;
			overrun_flag <= 1'b0;
		end else begin
			tx_pend <= tx_set || (tx_pend && !tx_served && !wr_thr); // see RL14
			tmo_pend <= tmo_expire || (tmo_pend && !rd_rhr); // see RL10
			gpio_pend <= gpio_toggle || (gpio_pend && !rd_io); // see RL12
			xoff_pend <= (xoff_gate && flow.xoff_match) ||
				(xoff_pend && !flow.xon_match); // see RL22
			spec_pend <= (xoff_gate && flow.special_match) ||
				(spec_pend && !spec_served); // see RL15
			flow_pend <= flow_set || (flow_pend && !rd_msr); // see RL15
			overrun_flag <= rx.overrun_evt || (overrun_flag && !rd_lsr); // see RL4
		end
	end

	// Edge history, read data and interrupt output
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_above_q <= 1'b0;
			tx_empty_q <= 1'b0;
			rts_q <= 1'b0;
			cts_q <= 1'b0;
			gpio_q <= '0;
			rd_data <= 8'h00;
			irq <= 1'b0;
			sleep_enable <= 1'b0;
		end else begin
			tx_above_q <= tx_above;
			tx_empty_q <= tx_empty_now;
			rts_q <= flow.rts_out;
			cts_q <= flow.cts_in;
			gpio_q <= gpio_in;
			if (host.rd)
				rd_data <= next_rd;
			irq <= any_pend; // see RL24
			sleep_enable <= interrupt_mask_reg[4];
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_rising_empty;
		!tx_above_q && tx_above;
	endsequence

	a_tx_ready_set: assert property (s_rising_empty |=> tx_pend)
		else $error("transmit-ready not raised"); // see RL1
	a_tx_enable_now: assert property (tx_en_rise && tx_ready_cond |=> tx_pend)
		else $error("enable on empty not raised"); // see RL2
	a_line_irq: assert property (p_line |=> irq &&
		$past(src_code) == `SRC_LINE) else $error("line status lost"); // see RL3
	a_overrun_now: assert property (rx.overrun_evt |=> overrun_flag)
		else $error("overrun not flagged"); // see RL4
	a_tx_clear: assert property (wr_thr && !tx_set |=> !tx_pend)
		else $error("holding write did not clear"); // see RL14
	a_lock_bits: assert property (wr_mask && !flow.unlock |=>
		interrupt_mask_reg[7:4] == $past(interrupt_mask_reg[7:4]))
		else $error("locked mask bits changed"); // see RL7
	a_none_code: assert property (!any_pend |-> src_code == `SRC_NONE)
		else $error("idle code wrong"); // see RL17
	a_fifo_bits: assert property (host.rd && host.addr == `OFS_INT_SOURCE
		|=> rd_data[7:6] == {2{$past(fifo_enable)}})
		else $error("fifo status bits wrong"); // see RL18
	a_reset_pulse: assert property (rx_fifo_reset |=> !rx_fifo_reset)
		else $error("fifo reset not self-clearing"); // see RL20
	a_gpio_clear: assert property (rd_io && !gpio_toggle |=> !gpio_pend)
		else $error("input interrupt not cleared"); // see RL12
	a_irq_follow: assert property (irq == $past(any_pend))
		else $error("interrupt output mismatch"); // see RL24
endmodule // uart_interrupt_fifo_control

// ==== verif/host_model.sv ====
`timescale 1ns/1ns

module host_model (
	input wire logic ref_clk,
	input wire logic [7:0] rd_data,
	output uart_int_pkg::host_req_t host
);
	initial begin
		host = '0;
	end

	// Request held from just after one edge to just after the taking edge
	task automatic write(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		host.wr = 1'b1;
		host.addr = a;
		host.wdata = d;
		@(posedge ref_clk);
		#1;
		host.wr = 1'b0;
		host.wdata = ~d;
	endtask

	task automatic read(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#1;
		host.rd = 1'b1;
		host.addr = a;
		@(posedge ref_clk);
		#1;
		host.rd = 1'b0;
		d = rd_data;
	endtask
endmodule // host_model

// ==== verif/uart_interrupt_fifo_control_bench.sv ====
`timescale 1ns/1ns

module uart_interrupt_fifo_control_bench;
	logic ref_clk;
	logic sys_rst;
	uart_int_pkg::host_req_t host;
	uart_int_pkg::rx_status_t rx;
	uart_int_pkg::tx_status_t tx;
	uart_int_pkg::flow_status_t flow;
	logic [7:0] gpio_in;
	logic bit_tick = 1'b0;
	logic [3:0] char_bits;
	logic [7:0] rd_data;
	logic irq, fifo_enable, rx_fifo_reset, tx_fifo_reset;
	logic [1:0] tx_trig_sel, rx_trig_sel;
	logic sleep_enable, overrun_flag;
	int errors = 0;
	int check_count = 0;
	logic [7:0] rd_chk;

	uart_interrupt_fifo_control u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.host(host), .rx(rx), .tx(tx), .flow(flow), .gpio_in(gpio_in),
		.bit_tick(bit_tick), .char_bits(char_bits), .rd_data(rd_data),
		.irq(irq), .fifo_enable(fifo_enable), .rx_fifo_reset(rx_fifo_reset),
		.tx_fifo_reset(tx_fifo_reset), .tx_trig_sel(tx_trig_sel),
		.rx_trig_sel(rx_trig_sel), .sleep_enable(sleep_enable),
		.overrun_flag(overrun_flag));
	host_model u_host (.ref_clk(ref_clk), .rd_data(rd_data), .host(host));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// One-cycle bit pulse every second cycle
	always @(posedge ref_clk) #1 bit_tick = ~bit_tick;

	task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic src(input logic [7:0] e);
		logic [7:0] d;
		u_host.read(4'h2, d);
		check("source", e, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.read(a, d);
		check("readback", e, d);
	endtask
	task conclude;
		$display("Comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task t_reset;
		src(8'h01);
		check("irq", 8'h00, {7'h00, irq});
		rd(4'h1, 8'h00);
	endtask
	task t_fifo;
		u_host.write(4'h2, 8'h07);
		check("rx reset", 8'h01, {7'h00, rx_fifo_reset});
		check("tx reset", 8'h01, {7'h00, tx_fifo_reset});
		tick(1);
		check("resets off", 8'h00, {6'h00, rx_fifo_reset, tx_fifo_reset});
		src(8'hc1);
		u_host.write(4'h2, 8'h31);
		check("tx trig locked", 8'h00, {6'h00, tx_trig_sel});
		flow.unlock = 1'b1;
		u_host.write(4'h2, 8'hf1);
		check("trig sel", 8'h0f, {4'h0, rx_trig_sel, tx_trig_sel});
		u_host.write(4'h2, 8'h00);
		check("fifo off", 8'h03, {fifo_enable, tx_trig_sel});
		src(8'h01);
		u_host.write(4'h2, 8'h01);
	endtask
	task t_mask;
		flow.unlock = 1'b0;
		u_host.write(4'h1, 8'hf0);
		rd(4'h1, 8'h00);
		flow.unlock = 1'b1;
		u_host.write(4'h1, 8'h10);
		tick(1);
		check("sleep", 8'h01, {7'h00, sleep_enable});
		u_host.write(4'h1, 8'h00);
	endtask
	task t_tx;
		u_host.write(4'h1, 8'h02);
		tick(3);
		check("irq", 8'h01, {7'h00, irq});
		src(8'hc2);
		src(8'hc1);
		u_host.write(4'h1, 8'h00);
		u_host.write(4'h1, 8'h02);
		u_host.write(4'h0, 8'h55);
		tick(2);
		src(8'hc1);
		tick(2);
		check("irq off", 8'h00, {7'h00, irq});
	endtask
	task t_line;
		// Re-arm transmit-ready so it waits queued behind line status
		u_host.write(4'h1, 8'h00);
		u_host.write(4'h1, 8'h06);
		rx.err_in_fifo = 1'b1;
		tick(3);
		src(8'hc6);
		src(8'hc6);
		rx.err_in_fifo = 1'b0;
		tick(3);
		src(8'hc2);
		rx.overrun_evt = 1'b1;
		tick(1);
		rx.overrun_evt = 1'b0;
		tick(2);
		check("overrun", 8'h01, {7'h00, overrun_flag});
		src(8'hc6);
		rd(4'h5, 8'h00);
		tick(2);
		src(8'hc1);
	endtask
	task t_rx;
		logic [7:0] d;
		u_host.write(4'h1, 8'h01);
		rx.level = 7'h08;
		tick(3);
		src(8'hc4);
		rx.level = 7'h01;
		tick(3);
		src(8'hc1);
		for (int i = 0; i < 300 && d !== 8'hcc; i++) u_host.read(4'h2, d);
		check("timeout", 8'hcc, d);
		u_host.read(4'h0, d);
		src(8'hc1);
		rx.level = 7'h00;
		u_host.write(4'h1, 8'h00);
	endtask
	task t_misc;
		gpio_in[3] = 1'b1;
		tick(3);
		src(8'hf0);
		rd(4'hb, 8'h00);
		src(8'hc1);
		u_host.write(4'h1, 8'h20);
		flow.xoff_match = 1'b1;
		tick(1);
		flow.xoff_match = 1'b0;
		tick(3);
		src(8'hd0);
		src(8'hd0);
		flow.xon_match = 1'b1;
		tick(1);
		flow.xon_match = 1'b0;
		tick(3);
		src(8'hc1);
		flow.special_match = 1'b1;
		tick(1);
		flow.special_match = 1'b0;
		tick(3);
		src(8'hd0);
		src(8'hc1);
		u_host.write(4'h1, 8'hc0);
		flow.auto_rts = 1'b1;
		flow.rts_out = 1'b1;
		tick(3);
		src(8'he0);
		u_host.read(4'h6, rd_chk);
		src(8'hc1);
		flow.auto_cts = 1'b1;
		flow.cts_in = 1'b1;
		tick(3);
		src(8'he0);
		u_host.write(4'h1, 8'h08);
		u_host.read(4'h6, rd_chk);
		flow.msr_delta = 1'b1;
		tick(3);
		src(8'hc0);
		flow.msr_delta = 1'b0;
		u_host.read(4'h6, rd_chk);
		src(8'hc1);
	endtask

	initial begin
		sys_rst = 1'b1;
		rx = '0;
		tx = '{spaces: 7'h40, thr_empty: 1'b1, tx_empty: 1'b1};
		flow = '0;
		gpio_in = 8'h00;
		char_bits = 4'ha;
		tick(2);
		sys_rst = 1'b0;
		t_reset();
		t_fifo();
		t_mask();
		t_tx();
		t_line();
		t_rx();
		t_misc();
		conclude();
	end
	initial begin
		#2000000;
		errors++;
		conclude();
	end
endmodule // uart_interrupt_fifo_control_bench
